// ### rtl/start_pkg.sv
/*
 Constants and types shared by the start-up path selector, its
 velocity constant decoder and its brake timer.
 Assumes a single 20 MHz clock for all users of the package.
*/
package start_pkg;

	// Clock rate
	localparam int unsigned CLK_HZ = 20_000_000;

	// Velocity constant code layout: mantissa low, exponent high
	localparam int KT_CODE_W = 7;
	localparam int KT_MANT_LSB = 0;
	localparam int KT_MANT_MSB = 3;
	localparam int KT_EXP_LSB = 4;
	localparam int KT_EXP_MSB = 6;
	localparam int KT_LIN_W = 11;
	localparam logic [6:0] KT_CODE_ZERO = 7'h00;
	localparam logic [6:0] KT_CODE_MIN = 7'h01;
	localparam logic [6:0] KT_CODE_MAX = 7'h7F;
	localparam logic [10:0] KT_LIN_ZERO = 11'h000;
	localparam logic [10:0] KT_LIN_MIN = 11'h001;
	localparam logic [10:0] KT_LIN_MAX = 11'h780;
	// Weight software applies per V/Hz before encoding
	localparam int KT_WEIGHT = 1090;

	// Brake duration: field value times one step
	localparam int BRAKE_FIELD_W = 3;
	localparam logic [2:0] BRAKE_OFF = 3'h0;
	localparam int unsigned BRAKE_STEP_MS = 10;
	localparam int unsigned BRAKE_STEP_CYCLES = BRAKE_STEP_MS * (CLK_HZ / 1000);
	localparam int BRAKE_PRE_W = 18;

	// Reset values of the pin synchroniser
	localparam logic DIR_RESET = 1'b0;

	// Initial motor condition seen by the start-up logic
	typedef enum logic [1:0] {
		COND_NONE,
		COND_STATIONARY,
		COND_FORWARD,
		COND_REVERSE
	} motor_cond_t;

	// Start-up sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SENSE,
		ST_REVERSE,
		ST_BRAKE,
		ST_COAST,
		ST_IPD,
		ST_ALIGN,
		ST_ACCEL,
		ST_CLOSED
	} start_state_t;

endpackage

// ### rtl/start_link_if.sv
/*
 Signals passed between the start-up selector and its two helpers:
 the velocity constant decoder and the brake timer.
 Assumes all parties share one clock; the interface itself holds no state.
*/
`timescale 1ns/1ps
interface start_link_if;
	logic [6:0] kt_code;
	logic [10:0] kt_lin;
	logic brake_go;
	logic [2:0] brake_len;
	logic brake_done;

	modport decoder (input kt_code, output kt_lin);
	modport timer (input brake_go, input brake_len, output brake_done);
	modport ctrl (output kt_code, output brake_go, output brake_len,
		input kt_lin, input brake_done);
endinterface

// ### rtl/kt_decode.sv
/*
 Combinational decoder of the 7-bit velocity constant code into its
 11-bit linear value.
 Assumes the code is held stable by the configuration registers.
*/
`timescale 1ns/1ps
module kt_decode
	import start_pkg::*;
(
	start_link_if.decoder lnk
);

	logic [10:0] mant_wide;

	// Mantissa widened first so the shift cannot lose upper bits
	assign mant_wide = {7'h00, lnk.kt_code[KT_MANT_MSB:KT_MANT_LSB]};
	assign lnk.kt_lin = mant_wide << lnk.kt_code[KT_EXP_MSB:KT_EXP_LSB];

endmodule

// ### rtl/brake_timer.sv
/*
 Brake duration timer: a step prescaler and a step counter loaded from
 the brake duration field.
 Assumes the go pulse comes from logic on the same clock.
*/
`timescale 1ns/1ps
module brake_timer
	import start_pkg::*;
#(
	parameter int unsigned STEP_CYCLES = BRAKE_STEP_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	start_link_if.timer lnk
);

	typedef struct packed {
		logic active;
		logic [17:0] pre;
		logic [2:0] left;
		logic done;
	} timer_st_t;

	timer_st_t s_q;
	timer_st_t s_d;

	// Step tick from the prescaler, counted down per field unit
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (lnk.brake_go && lnk.brake_len != BRAKE_OFF) begin
			s_d.active = 1'b1;
			s_d.pre = '0;
			s_d.left = lnk.brake_len;
		end else if (s_q.active) begin
			if (s_q.pre == BRAKE_PRE_W'(STEP_CYCLES - 1)) begin
				s_d.pre = '0;
				if (s_q.left == 3'h1) begin
					s_d.active = 1'b0;
					s_d.done = 1'b1;
				end else begin
					s_d.left = s_q.left - 3'h1;
				end
			end else begin
				s_d.pre = s_q.pre + 18'h00001;
			end
		end
	end

	// State register
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign lnk.brake_done = s_q.done;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_timer_start_load: assert property (
		lnk.brake_go && lnk.brake_len != BRAKE_OFF |=> s_q.active && s_q.pre == '0)
		else $error("brake timer did not start on go");
	a_done_single_pulse: assert property (
		s_q.done |=> !s_q.done && !s_q.active)
		else $error("brake done not a single pulse");

endmodule

// ### rtl/start_selector.sv
/*
 Start-up path selector of a sensorless three-phase motor driver.
 Chooses resync, reverse drive, brake, coast wait, inductive sensing or
 alignment from the sensed initial motor condition, and decodes the
 velocity constant. Assumes speed sensing, position sensing, alignment,
 acceleration and drive stages are neighbouring logic on the same clock;
 only the direction pin comes from outside and is synchronised here.
*/
`timescale 1ns/1ps
module start_selector
	import start_pkg::*;
#(
	parameter int unsigned BRAKE_STEP_CYC = BRAKE_STEP_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic run_cmd,
	input wire logic dir_pin,
	input wire logic [6:0] velocity_constant_code,
	input wire logic isd_enable,
	input wire logic resync_enable,
	input wire logic reverse_drive_enable,
	input wire logic [2:0] brake_duration_field,
	input wire logic inductive_position_sense_enable,
	input wire logic isd_done,
	input wire logic isd_stationary,
	input wire logic isd_forward,
	input wire logic rev_speed_over_thr,
	input wire logic position_done,
	input wire logic zero_speed_reached,
	input wire logic closed_loop_speed_reached,
	output logic [10:0] kt_linear,
	output motor_cond_t motor_cond,
	output logic isd_start,
	output logic ipd_start,
	output logic align_start,
	output logic reverse_drive_on,
	output logic [2:0] low_side_on,
	output logic accel_on,
	output logic closed_loop_on,
	output logic phases_floating
);

	typedef struct packed {
		start_state_t state;
		motor_cond_t cond;
		logic dir_s1;
		logic dir_s2;
		logic dir_s3;
		logic [10:0] kt_lin;
		logic isd_go;
		logic ipd_go;
		logic align_go;
		logic rvs_on;
		logic [2:0] lows;
		logic accel;
		logic closed;
		logic float_o;
		logic brake_go;
	} sel_st_t;

	sel_st_t s_q;
	sel_st_t s_d;
	logic dir_chg;

	start_link_if lnk ();

	// Helpers share the interface; decoder is pure logic
	kt_decode u_kt (
		.lnk(lnk.decoder)
	);

	brake_timer #(
		.STEP_CYCLES(BRAKE_STEP_CYC)
	) u_brake (
		.clock(clock),
		.sys_rst(sys_rst),
		.lnk(lnk.timer)
	);

	assign lnk.kt_code = velocity_constant_code;
	assign lnk.brake_go = s_q.brake_go;
	assign lnk.brake_len = brake_duration_field;

	// Rest-state start: inductive sensing when enabled, otherwise alignment
	function automatic start_state_t init_path(input logic ipd_en);
		return ipd_en ? ST_IPD : ST_ALIGN;
	endfunction

	// Brake first when its duration is nonzero, else start from rest
	function automatic start_state_t rest_path(input logic [2:0] brk, input logic ipd_en);
		return (brk != BRAKE_OFF) ? ST_BRAKE : init_path(ipd_en);
	endfunction

	// Direction change seen on synchronised samples only
	assign dir_chg = s_q.dir_s2 ^ s_q.dir_s3;

	// Next state and registered outputs
	always_comb begin
		s_d = s_q;
		s_d.dir_s1 = dir_pin;
		s_d.dir_s2 = s_q.dir_s1;
		s_d.dir_s3 = s_q.dir_s2;
		s_d.kt_lin = lnk.kt_lin;
		unique case (s_q.state)
			ST_IDLE: begin
				if (run_cmd) begin
					if (isd_enable) begin
						s_d.state = ST_SENSE;
					end else begin
						// Without sensing the motor is taken as standing
						s_d.cond = COND_STATIONARY;
						s_d.state = rest_path(brake_duration_field,
							inductive_position_sense_enable);
					end
				end
			end
			ST_SENSE: begin
				// Condition latched here on each verdict and held to closed loop
				if (isd_done) begin
					if (isd_stationary) begin
						s_d.cond = COND_STATIONARY;
						s_d.state = rest_path(brake_duration_field,
							inductive_position_sense_enable);
					end else if (isd_forward) begin
						s_d.cond = COND_FORWARD;
						if (resync_enable) begin
							s_d.state = ST_CLOSED;
						end else begin
							s_d.state = rest_path(brake_duration_field,
								inductive_position_sense_enable);
						end
					end else begin
						s_d.cond = COND_REVERSE;
						if (rev_speed_over_thr) begin
							s_d.state = ST_SENSE;
						end else if (reverse_drive_enable) begin
							s_d.state = ST_REVERSE;
						end else if (brake_duration_field != BRAKE_OFF) begin
							s_d.state = ST_BRAKE;
						end else begin
							s_d.state = ST_COAST;
						end
					end
				end
			end
			ST_REVERSE: begin
				if (zero_speed_reached) begin
					s_d.state = ST_ACCEL;
				end
			end
			ST_BRAKE: begin
				// A done left from an abandoned brake may meet a fresh go pulse;
				// the timer reloads on that go, so that done is not ours
				if (lnk.brake_done && !s_q.brake_go) begin
					s_d.state = init_path(inductive_position_sense_enable);
				end
			end
			ST_COAST: begin
				// Keeps sensing until the motor reports rest
				if (isd_done && isd_stationary) begin
					s_d.state = init_path(inductive_position_sense_enable);
				end
			end
			ST_IPD, ST_ALIGN: begin
				if (position_done) begin
					s_d.state = ST_ACCEL;
				end
			end
			ST_ACCEL: begin
				if (closed_loop_speed_reached) begin
					s_d.state = ST_CLOSED;
				end
			end
			ST_CLOSED: begin
				s_d.state = ST_CLOSED;
			end
		endcase
		// Run drop or direction change abandons the attempt
		if (!run_cmd || (dir_chg && s_q.state != ST_IDLE)) begin
			s_d.state = ST_IDLE;
		end
		if (s_d.state == ST_IDLE) begin
			s_d.cond = COND_NONE;
		end
		s_d.isd_go = (s_d.state == ST_SENSE || s_d.state == ST_COAST) &&
			(s_d.state != s_q.state || isd_done);
		s_d.ipd_go = (s_d.state == ST_IPD) && (s_q.state != ST_IPD);
		s_d.align_go = (s_d.state == ST_ALIGN) && (s_q.state != ST_ALIGN);
		s_d.brake_go = (s_d.state == ST_BRAKE) && (s_q.state != ST_BRAKE);
		s_d.rvs_on = (s_d.state == ST_REVERSE);
		s_d.lows = {3{s_d.state == ST_BRAKE}};
		s_d.accel = (s_d.state == ST_ACCEL);
		s_d.closed = (s_d.state == ST_CLOSED);
		// Phases stay open while back-EMF is watched or nothing runs
		s_d.float_o = (s_d.state == ST_IDLE || s_d.state == ST_SENSE ||
			s_d.state == ST_COAST);
	end

	// Single state register; every output comes from it
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '{state: ST_IDLE, cond: COND_NONE, dir_s1: DIR_RESET,
				dir_s2: DIR_RESET, dir_s3: DIR_RESET, kt_lin: KT_LIN_ZERO,
				lows: 3'h0, float_o: 1'b1, default: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign kt_linear = s_q.kt_lin;
	assign motor_cond = s_q.cond;
	assign isd_start = s_q.isd_go;
	assign ipd_start = s_q.ipd_go;
	assign align_start = s_q.align_go;
	assign reverse_drive_on = s_q.rvs_on;
	assign low_side_on = s_q.lows;
	assign accel_on = s_q.accel;
	assign closed_loop_on = s_q.closed;
	assign phases_floating = s_q.float_o;

	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Sensing verdicts seen while the attempt stays alive
	sequence s_live_sense;
		s_q.state == ST_SENSE && isd_done && run_cmd && !dir_chg;
	endsequence
	sequence s_rev_slow;
		s_live_sense ##0 !isd_stationary && !isd_forward && !rev_speed_over_thr;
	endsequence

	a_kt_max_code: assert property (
		velocity_constant_code == KT_CODE_MAX |=> kt_linear == KT_LIN_MAX)
		else $error("all-ones code not decoded to 1920");
	a_kt_min_code: assert property (
		velocity_constant_code == KT_CODE_MIN |=> kt_linear == KT_LIN_MIN)
		else $error("code one not decoded to one");
	a_kt_zero_code: assert property (
		velocity_constant_code == KT_CODE_ZERO |=> kt_linear == KT_LIN_ZERO)
		else $error("code zero not decoded to zero");
	a_kt_shift_form: assert property (
		##1 kt_linear == ({7'h00, $past(velocity_constant_code[3:0])}
			<< $past(velocity_constant_code[6:4])))
		else $error("linear value is not mantissa shifted by exponent");
	a_resync_direct: assert property (
		s_live_sense ##0 !isd_stationary && isd_forward && resync_enable
			|=> closed_loop_on && motor_cond == COND_FORWARD)
		else $error("forward motor not resynchronised into closed loop");
	a_fast_reverse_retry: assert property (
		s_live_sense ##0 !isd_stationary && !isd_forward && rev_speed_over_thr
			|=> isd_start && !reverse_drive_on && low_side_on == 3'h0)
		else $error("fast reverse motor not sent back to sensing");
	a_reverse_drive_sel: assert property (
		s_rev_slow ##0 reverse_drive_enable |=> reverse_drive_on ##1
			(reverse_drive_on || !run_cmd || accel_on || $past(dir_chg)))
		else $error("reverse drive not engaged for slow reverse motor");
	a_brake_lows_on: assert property (
		low_side_on != 3'h0 |-> low_side_on == 3'h7 && brake_duration_field != BRAKE_OFF
			|| $past(low_side_on) == 3'h7)
		else $error("low sides not all on together during brake");
	a_coast_no_brake: assert property (
		s_rev_slow ##0 !reverse_drive_enable && brake_duration_field == BRAKE_OFF
			|=> phases_floating && isd_start && low_side_on == 3'h0)
		else $error("coasting reverse motor not left floating");
	a_brake_then_init: assert property (
		s_q.state == ST_BRAKE && lnk.brake_done && !s_q.brake_go && run_cmd && !dir_chg
			|=> (ipd_start ^ align_start) && low_side_on == 3'h0)
		else $error("brake end did not start position initialisation");
	a_cond_held: assert property (
		s_q.state != ST_IDLE && s_q.state != ST_SENSE && run_cmd && !dir_chg
			|=> $stable(motor_cond))
		else $error("start path condition changed before closed loop");

endmodule

// ### verif/motor_model.sv
/*
 Behavioural stand-in for the motor and the sensing stages beside the selector.
 Assumes the selector's start pulses and drive levels share its clock.
*/
`timescale 1ns/1ps
module motor_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] dly,
	input wire logic v_stat,
	input wire logic v_fwd,
	input wire logic v_over,
	input wire logic isd_start,
	input wire logic ipd_start,
	input wire logic align_start,
	input wire logic reverse_drive_on,
	input wire logic accel_on,
	output logic isd_done,
	output logic isd_stationary,
	output logic isd_forward,
	output logic rev_speed_over_thr,
	output logic position_done,
	output logic zero_speed_reached,
	output logic closed_loop_speed_reached
);
	logic [7:0] cnt_q;
	logic [2:0] kind_q;
	logic tgl_q;
	logic rev_q;
	logic acc_q;
	logic fire;

	// One job at a time; a fresh start restarts the delay
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= 8'h00;
			kind_q <= 3'h0;
			tgl_q <= 1'b0;
			rev_q <= 1'b0;
			acc_q <= 1'b0;
		end else begin
			tgl_q <= ~tgl_q;
			rev_q <= reverse_drive_on;
			acc_q <= accel_on;
			if (isd_start) begin
				kind_q <= 3'h1;
				cnt_q <= dly;
			end else if (ipd_start | align_start) begin
				kind_q <= 3'h2;
				cnt_q <= dly;
			// No energy flows back here: current and supply surge taken as limited
			end else if (reverse_drive_on & ~rev_q) begin
				kind_q <= 3'h3;
				cnt_q <= dly;
			end else if (accel_on & ~acc_q) begin
				kind_q <= 3'h4;
				cnt_q <= dly;
			end else if (cnt_q != 8'h00) begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end

	// Verdict lines churn outside the done cycle so stale sampling shows
	assign fire = (cnt_q == 8'h01);
	assign isd_done = fire & (kind_q == 3'h1);
	assign isd_stationary = isd_done ? v_stat : tgl_q;
	assign isd_forward = isd_done ? v_fwd : ~tgl_q;
	assign rev_speed_over_thr = isd_done ? v_over : tgl_q;
	assign position_done = fire & (kind_q == 3'h2);
	assign zero_speed_reached = fire & (kind_q == 3'h3);
	assign closed_loop_speed_reached = fire & (kind_q == 3'h4);
endmodule

// ### verif/start_selector_tb.sv
/*
 Self-checking bench of the start-up path selector.
 Assumes the motor model answers for the sensing stages and the motor.
*/
`timescale 1ns/1ps
module start_selector_tb;
	import start_pkg::*;
	localparam int unsigned STEP = 4;
	typedef struct packed {
		logic isd_en;
		logic stat;
		logic fwd;
		logic rsy;
		logic rvs;
		logic [2:0] brk;
		logic inductive_position_sense;
		logic [4:0] mask;
		logic [1:0] cond;
	} path_row_t;
	logic clock, sys_rst, run_cmd, dir_pin, isd_enable, resync_enable;
	logic reverse_drive_enable, inductive_position_sense_enable, v_stat, v_fwd, v_over;
	logic [6:0] velocity_constant_code;
	logic [2:0] brake_duration_field, low_side_on;
	logic [7:0] dly;
	logic [10:0] kt_linear;
	motor_cond_t motor_cond;
	logic isd_start, ipd_start, align_start, reverse_drive_on, accel_on, closed_loop_on;
	logic phases_floating, isd_done, isd_stationary, isd_forward, rev_speed_over_thr;
	logic position_done, zero_speed_reached, closed_loop_speed_reached;
	int fails, n_compared, c_isd, c_ipd, c_aln, c_rev, c_brk, bad_low;
	int s_isd, s_ipd, s_aln, s_rev, s_brk, k;
	logic [17:0] kt_rows [8] = '{{7'h00, 11'h000}, {7'h01, 11'h001}, {7'h0F, 11'h00F},
		{7'h18, 11'h010}, {7'h4E, 11'h0E0}, {7'h5A, 11'h140}, {7'h70, 11'h000},
		{7'h7F, 11'h780}};
	// isd_en stat fwd rsy rvs brk ipd | mask {isd ipd align rev brake} cond
	path_row_t rows [7] = '{'{1, 1, 0, 0, 0, 0, 1, 5'b11000, 1}, '{1, 1, 0, 0, 0, 0, 0, 5'b10100, 1},
		'{1, 0, 1, 1, 0, 0, 1, 5'b10000, 2}, '{1, 0, 0, 0, 1, 0, 1, 5'b10010, 3},
		'{1, 0, 0, 0, 0, 2, 0, 5'b10101, 3}, '{0, 0, 0, 0, 0, 0, 1, 5'b01000, 1},
		'{1, 0, 1, 0, 0, 1, 1, 5'b11001, 2}};

	start_selector #(.BRAKE_STEP_CYC(STEP)) i_dut (.clock, .sys_rst, .run_cmd, .dir_pin,
		.velocity_constant_code, .isd_enable, .resync_enable, .reverse_drive_enable,
		.brake_duration_field, .inductive_position_sense_enable, .isd_done, .isd_stationary,
		.isd_forward, .rev_speed_over_thr, .position_done, .zero_speed_reached,
		.closed_loop_speed_reached, .kt_linear, .motor_cond, .isd_start, .ipd_start,
		.align_start, .reverse_drive_on, .low_side_on, .accel_on, .closed_loop_on,
		.phases_floating);
	motor_model i_motor (.clock, .sys_rst, .dly, .v_stat, .v_fwd, .v_over, .isd_start,
		.ipd_start, .align_start, .reverse_drive_on, .accel_on, .isd_done, .isd_stationary,
		.isd_forward, .rev_speed_over_thr, .position_done, .zero_speed_reached,
		.closed_loop_speed_reached);

	always #25 clock = ~clock;

	// Running tallies; tests compare differences, except bad_low checked against zero; never reset them
	always @(posedge clock) begin
		c_isd += isd_start;
		c_ipd += ipd_start;
		c_aln += align_start;
		c_rev += reverse_drive_on;
		c_brk += (low_side_on == 3'h7);
		bad_low += (low_side_on !== 3'h0 && low_side_on !== 3'h7);
	end

	task automatic chk(input string what, input logic [10:0] exp, input logic [10:0] got);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Configure one attempt and take a snapshot of the tallies
	task automatic setup(input path_row_t r);
		isd_enable = r.isd_en;
		v_stat = r.stat;
		v_fwd = r.fwd;
		v_over = 1'b0;
		resync_enable = r.rsy;
		reverse_drive_enable = r.rvs;
		brake_duration_field = r.brk;
		inductive_position_sense_enable = r.inductive_position_sense;
		dly = 8'h03;
		{s_isd, s_ipd, s_aln, s_rev, s_brk} = {c_isd, c_ipd, c_aln, c_rev, c_brk};
	endtask

	// Bounded wait for closed loop, then check the path taken
	task automatic finish(input path_row_t r);
		logic [4:0] seen;
		k = 0;
		while (closed_loop_on !== 1'b1 && k < 3000) begin
			tick(1);
			k++;
		end
		seen = {c_isd != s_isd, c_ipd != s_ipd, c_aln != s_aln, c_rev != s_rev, c_brk != s_brk};
		chk("closed loop", 11'h001, 11'(closed_loop_on));
		chk("path", 11'(r.mask), 11'(seen));
		chk("condition", 11'(r.cond), 11'(motor_cond));
		run_cmd = 1'b0;
		tick(3);
		chk("floating", 11'h001, 11'(phases_floating));
	endtask

	task automatic wait_isd(input int tgt);
		k = 0;
		while (c_isd < tgt && k < 2000) begin
			tick(1);
			k++;
		end
		chk("isd restarts", 11'h001, 11'(c_isd >= tgt));
	endtask

	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		run_cmd = 1'b0;
		dir_pin = 1'b0;
		velocity_constant_code = 7'h00;
		setup(rows[0]);
		repeat (6) @(posedge clock);
		#2;
		// Checked after clock edges so a missed time-zero reset edge cannot matter
		chk("reset kt", 11'h000, kt_linear);
		chk("reset float", 11'h001, 11'(phases_floating));
		chk("reset cond", 11'h000, 11'(motor_cond));
		$display("test reset done");
		sys_rst = 1'b0;
		// Codes formed from the weighted value by software
		for (int i = 0; i < 8; i++) begin
			velocity_constant_code = kt_rows[i][17:11];
			tick(1);
			chk("kt", kt_rows[i][10:0], kt_linear);
		end
		$display("test decode done");
		for (int i = 0; i < 7; i++) begin
			setup(rows[i]);
			run_cmd = 1'b1;
			finish(rows[i]);
		end
		$display("test paths done");
		// Longest brake: all low sides for field times step
		setup('{0, 0, 0, 0, 0, 7, 0, 5'b00101, 1});
		run_cmd = 1'b1;
		finish('{0, 0, 0, 0, 0, 7, 0, 5'b00101, 1});
		k = c_brk - s_brk;
		chk("brake span", 11'h001, 11'(k >= 7 * STEP && k <= 7 * STEP + 2));
		chk("low side", 11'h000, 11'(bad_low));
		$display("test brake done");
		// Fast reverse spin goes back to sensing before reverse drive
		setup(rows[3]);
		v_over = 1'b1;
		run_cmd = 1'b1;
		wait_isd(s_isd + 3);
		chk("no early drive", 11'h000, 11'(c_rev - s_rev));
		v_over = 1'b0;
		finish(rows[3]);
		$display("test threshold done");
		// Coasting reverse motor: sensing repeats until it stands still
		setup('{1, 0, 0, 0, 0, 0, 1, 5'b11000, 1});
		run_cmd = 1'b1;
		wait_isd(s_isd + 3);
		chk("no init yet", 11'h000, 11'(c_ipd - s_ipd));
		v_stat = 1'b1;
		finish('{1, 0, 0, 0, 0, 0, 1, 5'b11000, 3});
		$display("test coast done");
		// Direction change mid-acceleration restarts, slow partner
		setup(rows[1]);
		dly = 8'h28;
		run_cmd = 1'b1;
		k = 0;
		while (accel_on !== 1'b1 && k < 2000) begin
			tick(1);
			k++;
		end
		chk("accel reached", 11'h001, 11'(accel_on));
		dir_pin = 1'b1;
		tick(6);
		chk("restart accel", 11'h000, 11'(accel_on));
		chk("restart sense", 11'h001, 11'(c_isd - s_isd > 1));
		finish(rows[1]);
		$display("test direction done");
		wrap_up();
	end

	// Watchdog well past the expected run length
	initial begin
		#(30000 * 50);
		fails++;
		wrap_up();
	end
endmodule
